// File: boot_cfg.svh
`ifndef BOOT_CFG_SVH
`define BOOT_CFG_SVH

// Register byte offsets
`define REG_MODE_SENSE        8'h00
`define REG_BOOT_STATUS       8'h04
`define REG_BOOT_CONTROL      8'h08
`define REG_SECURE_ID         8'h0C

// Mode sense register fields
`define SENSE_PINS_LSB        0
`define SENSE_MODE_LSB        4

// Boot status register fields
`define STAT_INIT_FLAG        0
`define STAT_SECURE_OPEN      1
`define STAT_MCU_ROLE         2
`define STAT_REFUSED          3
`define STAT_CORE_RUN         4
`define STAT_STATE_LSB        8

// Boot control register bits (write one to act)
`define CTRL_INIT_DONE        0
`define CTRL_UNSEC_DONE       1
`define CTRL_CLR_REFUSED      2

// Secure master identity register fields
`define SECID_CPU_LSB         0
`define SECID_DMA_LSB         8

// Strap codes as {mode_sense_2, mode_sense_1, mode_sense_0}
`define STRAP_SERIAL_LOAD     3'h4
`define STRAP_TWO_WIRE        3'h1
`define STRAP_FOUR_WIRE       3'h0

// Reset values of the bus master identities
`define CPU_ID_RESET          4'h1
`define DMA_ID_RESET          4'h2
`define CPU_ID_APP            4'h3
`define DMA_ID_APP            4'h4

// Timing: least times, rounded up to whole 20 ns cycles
`define CLK_PERIOD_NS         20
`define STRAP_SETTLE_NS       1000
`define SELF_RESET_NS         200
`define STRAP_SETTLE_CYC      ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELF_RESET_CYC        ((`SELF_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: boot_pkg.sv
package boot_pkg;

  typedef enum logic [6:0] {
    ST_SAMPLE     = 7'h01,
    ST_DECIDE     = 7'h02,
    ST_INIT_RUN   = 7'h04,
    ST_SELF_RESET = 7'h08,
    ST_UNSEC_RUN  = 7'h10,
    ST_APP_RUN    = 7'h20,
    ST_LOAD_WAIT  = 7'h40
  } boot_state_t;

  typedef enum logic [1:0] {
    MODE_FOUR_WIRE   = 2'h0,
    MODE_TWO_WIRE    = 2'h1,
    MODE_SERIAL_LOAD = 2'h2,
    MODE_UNSUPPORTED = 2'h3
  } boot_mode_t;

  typedef enum logic [2:0] {
    FLOW_HOLD        = 3'h0,
    FLOW_INITIAL_ROM = 3'h1,
    FLOW_INIT_CODE   = 3'h2,
    FLOW_UNSECURE    = 3'h3,
    FLOW_APPLICATION = 3'h4,
    FLOW_SERIAL_LOAD = 3'h5
  } boot_flow_t;

  typedef struct packed {
    boot_state_t state;
    logic [2:0]  sense;
    boot_mode_t  mode;
    logic        init_flag;
    logic [3:0]  cpu_id;
    logic [3:0]  dma_id;
    logic [3:0]  pend_cpu_id;
    logic [3:0]  pend_dma_id;
    logic        refused;
    logic [15:0] count;
    logic [31:0] rdata;
  } boot_regs_t;

  typedef struct packed {
    logic [1:0] stage;
  } sync_regs_t;

endpackage

// File: reset_release_sync.sv
`timescale 1ns/1ps
module reset_release_sync (
  input  wire logic clk,
  input  wire logic resetn,
  output logic      rst_n
);
  import boot_pkg::*;

  sync_regs_t r;
  sync_regs_t next_r;

  // Assert at once, release two edges after resetn rises
  always_comb begin
    next_r.stage = {r.stage[0], 1'b1};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rst_n = r.stage[1];

endmodule

// File: boot_sequencer.sv
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "boot_cfg.svh"
module boot_sequencer #(
  parameter int SETTLE_CYCLES = `STRAP_SETTLE_CYC,
  parameter int RESET_CYCLES  = `SELF_RESET_CYC
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic         mode_sense_0,
  input  wire logic         mode_sense_1,
  input  wire logic         mode_sense_2,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_we,
  input  wire logic         reg_re,
  output logic [31:0]       reg_rdata,
  output logic              core_reset_n,
  output boot_pkg::boot_flow_t boot_flow,
  output logic              init_flag,
  output logic              secure_open,
  output logic              secure_refused,
  output logic              mcu_role,
  output logic [3:0]        cpu_master_id,
  output logic [3:0]        dma_master_id,
  output logic              functional_four_wire_debug,
  output logic              functional_two_wire_debug,
  output logic              serial_load_mode
);
  import boot_pkg::*;

  // Counter is 16 bits wide; a zero-length wait would wrap its load of count minus one to 65535
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end
  if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin : g_bad_reset
    $error("RESET_CYCLES out of range");
  end

  localparam int SR_DONE = RESET_CYCLES + 1;

  logic       rst_n;
  boot_regs_t r;
  boot_regs_t next_r;
  logic [2:0] strap;
  logic       secure_hit;
  logic       ctrl_write;
  boot_mode_t strap_mode;

  reset_release_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .rst_n  (rst_n)
  );

  assign strap      = {mode_sense_2, mode_sense_1, mode_sense_0};
  assign secure_hit = (reg_addr == `REG_SECURE_ID) && (reg_we || reg_re);
  assign ctrl_write = reg_we && (reg_addr == `REG_BOOT_CONTROL);

  always_comb begin
    unique case (strap)
      `STRAP_SERIAL_LOAD: strap_mode = MODE_SERIAL_LOAD;
      `STRAP_TWO_WIRE:    strap_mode = MODE_TWO_WIRE;
      `STRAP_FOUR_WIRE:   strap_mode = MODE_FOUR_WIRE;
      default:            strap_mode = MODE_UNSUPPORTED;
    endcase
  end

  always_comb begin
    next_r       = r;
    next_r.rdata = 32'h0000_0000;

    if (secure_hit && !r.init_flag) begin
      next_r.refused = 1'b1;
    end else if (ctrl_write && reg_wdata[`CTRL_CLR_REFUSED]) begin
      next_r.refused = 1'b0;
    end
    if (reg_we && reg_addr == `REG_SECURE_ID && r.init_flag) begin
      next_r.pend_cpu_id = reg_wdata[`SECID_CPU_LSB +: 4];
      next_r.pend_dma_id = reg_wdata[`SECID_DMA_LSB +: 4];
    end

    if (reg_re) begin
      unique case (reg_addr)
        `REG_MODE_SENSE: begin
          next_r.rdata[`SENSE_PINS_LSB +: 3] = r.sense;
          next_r.rdata[`SENSE_MODE_LSB +: 2] = r.mode;
        end
        `REG_BOOT_STATUS: begin
          next_r.rdata[`STAT_INIT_FLAG]      = r.init_flag;
          next_r.rdata[`STAT_SECURE_OPEN]    = secure_open;
          next_r.rdata[`STAT_MCU_ROLE]       = mcu_role;
          next_r.rdata[`STAT_REFUSED]        = r.refused;
          next_r.rdata[`STAT_CORE_RUN]       = core_reset_n;
          next_r.rdata[`STAT_STATE_LSB +: 7] = r.state;
        end
        `REG_SECURE_ID: begin
          // Locked reads return zero so nothing secure leaks out
          if (r.init_flag) begin
            next_r.rdata[`SECID_CPU_LSB +: 4] = r.pend_cpu_id;
            next_r.rdata[`SECID_DMA_LSB +: 4] = r.pend_dma_id;
          end
        end
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    unique case (r.state)
      ST_SAMPLE: begin
        // latch straps while the core is still held
        if (r.count == 16'h0000) begin
          // only this state writes the strap copy
          next_r.sense = strap;
          next_r.mode  = strap_mode;
          // flag set on leaving power-on reset
          next_r.init_flag = 1'b1;
          next_r.state     = ST_DECIDE;
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
      ST_DECIDE: begin
        // initial ROM code branches on the flag
        if (r.init_flag) begin
          next_r.state = ST_INIT_RUN;
        end else begin
          next_r.state = ST_UNSEC_RUN;
        end
      end
      ST_INIT_RUN: begin
        if (ctrl_write && reg_wdata[`CTRL_INIT_DONE]) begin
          next_r.init_flag = 1'b0;
          next_r.cpu_id    = r.pend_cpu_id;
          next_r.dma_id    = r.pend_dma_id;
          next_r.state = ST_SELF_RESET;
          next_r.count = 16'(RESET_CYCLES - 1);
        end
      end
      ST_SELF_RESET: begin
        if (r.count == 16'h0000) begin
          next_r.state = ST_DECIDE;
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
      ST_UNSEC_RUN: begin
        if (ctrl_write && reg_wdata[`CTRL_UNSEC_DONE]) begin
          if (r.mode == MODE_SERIAL_LOAD) begin
            next_r.state = ST_LOAD_WAIT;
          end else begin
            next_r.state = ST_APP_RUN;
          end
        end
      end
      ST_APP_RUN: begin
        next_r.state = ST_APP_RUN;
      end
      ST_LOAD_WAIT: begin
        // waits without limit for serial load
        next_r.state = ST_LOAD_WAIT;
      end
      default: begin
        next_r.state = ST_SAMPLE;
        next_r.count = 16'(SETTLE_CYCLES - 1);
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.state       <= ST_SAMPLE;
      r.sense       <= 3'h0;
      r.mode        <= MODE_FOUR_WIRE;
      r.init_flag   <= 1'b1;
      r.cpu_id      <= `CPU_ID_RESET;
      r.dma_id      <= `DMA_ID_RESET;
      r.pend_cpu_id <= `CPU_ID_APP;
      r.pend_dma_id <= `DMA_ID_APP;
      r.refused     <= 1'b0;
      r.count       <= 16'(SETTLE_CYCLES - 1);
      r.rdata       <= 32'h0000_0000;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign reg_rdata      = r.rdata;
  assign init_flag      = r.init_flag;
  assign secure_refused = r.refused;
  assign cpu_master_id  = r.cpu_id;
  assign dma_master_id  = r.dma_id;
  // core held in reset while sampling or self-resetting
  assign core_reset_n   = !(r.state == ST_SAMPLE || r.state == ST_SELF_RESET);
  // secure window tied to the init flag
  assign secure_open    = r.init_flag && core_reset_n;
  // MCU role once the application owns the core
  assign mcu_role       = (r.state == ST_APP_RUN);

  // pin mapping from the latched strap only
  assign functional_two_wire_debug  = (r.state != ST_SAMPLE) && (r.mode == MODE_TWO_WIRE);
  // four-wire debug also serves serial load
  assign functional_four_wire_debug = (r.state != ST_SAMPLE) &&
                                      (r.mode == MODE_FOUR_WIRE || r.mode == MODE_SERIAL_LOAD);
  assign serial_load_mode           = (r.state != ST_SAMPLE) && (r.mode == MODE_SERIAL_LOAD);

  // flow presented to the core fetch logic
  always_comb begin
    unique case (r.state)
      ST_DECIDE:    boot_flow = FLOW_INITIAL_ROM;
      ST_INIT_RUN:  boot_flow = FLOW_INIT_CODE;
      ST_UNSEC_RUN: boot_flow = FLOW_UNSECURE;
      ST_APP_RUN:   boot_flow = FLOW_APPLICATION;
      ST_LOAD_WAIT: boot_flow = FLOW_SERIAL_LOAD;
      default:      boot_flow = FLOW_HOLD;
    endcase
  end

  // Checks follow the frozen clock so clk_en low does not fake failures
  default clocking cb @(posedge clk iff clk_en);
  endclocking
  default disable iff (!rst_n);

  sequence s_leave_sample;
    (r.state == ST_SAMPLE) && (r.count == 16'h0000);
  endsequence

  sequence s_init_done;
    (r.state == ST_INIT_RUN) && ctrl_write && reg_wdata[`CTRL_INIT_DONE];
  endsequence

  sequence s_unsec_done;
    (r.state == ST_UNSEC_RUN) && ctrl_write && reg_wdata[`CTRL_UNSEC_DONE];
  endsequence

  a_init_flag_set: assert property (
    s_leave_sample |=> (r.init_flag && r.state == ST_DECIDE && r.sense == $past(strap)))
    else $error("init flag or strap copy wrong on leaving reset");

  a_sense_held: assert property (
    (r.state != ST_SAMPLE) |=> $stable(r.sense) && $stable(r.mode))
    else $error("strap copy changed after sampling");

  a_secure_lock: assert property (
    (reg_re && reg_addr == `REG_SECURE_ID && !r.init_flag) |=> (reg_rdata == 32'h0000_0000) && secure_refused)
    else $error("secure read not refused while locked");

  a_init_swap: assert property (
    s_init_done |=> (!r.init_flag && cpu_master_id == $past(r.pend_cpu_id)
                     && dma_master_id == $past(r.pend_dma_id)))
    else $error("init end did not clear flag and swap identities");

  a_self_reset: assert property (
    s_init_done |=> !core_reset_n ##[SR_DONE:SR_DONE] (r.state == ST_UNSEC_RUN))
    else $error("self-reset length or exit wrong");

  a_first_boot: assert property (
    (r.state == ST_DECIDE && r.init_flag) |=> (boot_flow == FLOW_INIT_CODE && secure_open))
    else $error("first boot did not enter init code");

  a_second_boot: assert property (
    (r.state == ST_DECIDE && !r.init_flag) |=> (boot_flow == FLOW_UNSECURE && !secure_open))
    else $error("second boot did not take unsecure path");

  a_app_handover: assert property (
    (s_unsec_done and (r.mode != MODE_SERIAL_LOAD)) |=> (mcu_role && boot_flow == FLOW_APPLICATION)[*3])
    else $error("application handover missing");

  a_role_locked: assert property (
    mcu_role |-> (!secure_open && !r.init_flag && core_reset_n))
    else $error("secure region open in MCU role");

  a_load_forever: assert property (
    (r.state == ST_LOAD_WAIT) |=> (r.state == ST_LOAD_WAIT) && serial_load_mode && functional_four_wire_debug)
    else $error("serial load mode left or mapped wrong");

  a_two_wire_map: assert property (
    (r.state != ST_SAMPLE) |-> (functional_two_wire_debug == (r.sense == `STRAP_TWO_WIRE)))
    else $error("two-wire debug map disagrees with strap");

  a_four_wire_map: assert property (
    (r.state != ST_SAMPLE && r.sense == `STRAP_FOUR_WIRE) |-> functional_four_wire_debug && !serial_load_mode)
    else $error("four-wire debug map disagrees with strap");

  a_held_sampling: assert property (
    (r.state == ST_SAMPLE) |-> (!core_reset_n && boot_flow == FLOW_HOLD && !functional_two_wire_debug))
    else $error("core released before straps latched");

  a_two_phase: assert property (
    (boot_flow == FLOW_APPLICATION) |-> $past(r.init_flag, 1) == 1'b0)
    else $error("application ran in setup phase");

  a_rom_first: assert property (
    $rose(core_reset_n) |-> boot_flow == FLOW_INITIAL_ROM)
    else $error("core left reset outside initial ROM code");

  // Refusal is sticky so software can find a locked access long after it happened
  sequence s_locked_access;
    secure_hit && !r.init_flag;
  endsequence

  a_refuse_set: assert property (
    s_locked_access |=> secure_refused)
    else $error("locked secure access not flagged");

  a_locked_write: assert property (
    (s_locked_access ##0 reg_we) |=> $stable(r.pend_cpu_id) && $stable(r.pend_dma_id))
    else $error("locked secure write changed pending identities");

  a_refuse_clear: assert property (
    (ctrl_write && reg_wdata[`CTRL_CLR_REFUSED]) |=> !secure_refused)
    else $error("refusal flag not cleared by software");

  a_ids_fixed: assert property (
    (r.state != ST_INIT_RUN) |=> $stable(cpu_master_id) && $stable(dma_master_id))
    else $error("master identity changed outside init end");

  a_flow_held: assert property (
    (r.state == ST_SELF_RESET) |-> (!core_reset_n && boot_flow == FLOW_HOLD && !secure_open && !init_flag))
    else $error("core not held during self-reset");

endmodule

// File: strap_model.sv
`timescale 1ns/1ps
module strap_model (
  input  wire logic       clk,
  input  wire logic [2:0] code,
  input  wire logic       reuse,
  output logic            mode_sense_0,
  output logic            mode_sense_1,
  output logic            mode_sense_2
);
  logic toggle = 1'b0;
  always @(posedge clk) begin
    toggle <= ~toggle;
  end
  assign mode_sense_0 = code[0];
  assign mode_sense_1 = code[1];
  // pin 2 reused as a toggling output once powered up
  assign mode_sense_2 = reuse ? toggle : code[2];
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`include "boot_cfg.svh"
module tb_top;
  import boot_pkg::*;
  localparam int SETTLE  = 3;
  localparam int RST_CYC = 3;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clk_en = 1'b1;
  logic [2:0]  code = 3'h0;
  logic        reuse = 1'b0;
  logic        mode_sense_0, mode_sense_1, mode_sense_2;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic        core_reset_n, init_flag, secure_open, secure_refused, mcu_role;
  boot_flow_t  boot_flow;
  logic [3:0]  cpu_master_id, dma_master_id;
  logic        four_w, two_w, serial_w;
  int          errors = 0;
  int          cmp_count = 0;

  always #10 clk = ~clk;

  strap_model i_strap_model (.clk(clk), .code(code), .reuse(reuse),
    .mode_sense_0(mode_sense_0), .mode_sense_1(mode_sense_1), .mode_sense_2(mode_sense_2));

  boot_sequencer #(.SETTLE_CYCLES(SETTLE), .RESET_CYCLES(RST_CYC)) i_boot_sequencer (
    .clk(clk), .resetn(resetn), .clk_en(clk_en),
    .mode_sense_0(mode_sense_0), .mode_sense_1(mode_sense_1), .mode_sense_2(mode_sense_2),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .core_reset_n(core_reset_n), .boot_flow(boot_flow),
    .init_flag(init_flag), .secure_open(secure_open), .secure_refused(secure_refused),
    .mcu_role(mcu_role), .cpu_master_id(cpu_master_id), .dma_master_id(dma_master_id),
    .functional_four_wire_debug(four_w), .functional_two_wire_debug(two_w),
    .serial_load_mode(serial_w));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask

  // Counts negedges with the core held in reset, bounded
  task automatic low_count(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 200) begin
      n++;
      @(negedge clk);
    end
  endtask

  // Clock enable low: a strobe must not be taken and the state must hold
  task automatic freeze_chk();
    @(posedge clk);
    clk_en <= 1'b0;
    wr(`REG_BOOT_CONTROL, 32'h2);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("frozen flow", boot_flow, FLOW_UNSECURE);
    @(posedge clk);
    clk_en <= 1'b1;
    @(negedge clk);
    chk("thawed flow", boot_flow, FLOW_UNSECURE);
  endtask

  task automatic boot_case(input logic [2:0] c, input logic [1:0] m, input logic [2:0] map);
    int n;
    logic serial;
    serial = map[0];
    @(posedge clk);
    resetn <= 1'b0;
    code <= c;
    reuse <= 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("held core", {init_flag, core_reset_n, secure_open}, 3'b100);
    chk("held flow", boot_flow, FLOW_HOLD);
    chk("held map", {four_w, two_w, serial_w}, 3'b000);
    @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    low_count(n);
    chk("first decide", boot_flow, FLOW_INITIAL_ROM);
    chk("map", {four_w, two_w, serial_w}, map);
    @(negedge clk);
    chk("init flow", boot_flow, FLOW_INIT_CODE);
    rd_chk("mode sense", `REG_MODE_SENSE, {26'h0, m, 1'b0, c});
    rd_chk("init status", `REG_BOOT_STATUS, 32'h0000_0413);
    wr(`REG_BOOT_CONTROL, 32'h2);
    rd_chk("early unsec", `REG_BOOT_STATUS, 32'h0000_0413);
    rd_chk("id reset", `REG_SECURE_ID, 32'h0000_0403);
    wr(`REG_SECURE_ID, 32'h0000_0A05);
    rd_chk("id back", `REG_SECURE_ID, 32'h0000_0A05);
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h10, 32'h0);
    chk("ids before", {cpu_master_id, dma_master_id}, 8'h12);
    @(posedge clk);
    reuse <= 1'b1;
    wr(`REG_BOOT_CONTROL, 32'h1);
    @(negedge clk);
    chk("flag cleared", init_flag, 1'b0);
    chk("ids after", {cpu_master_id, dma_master_id}, 8'h5A);
    low_count(n);
    chk("self reset len", n, RST_CYC);
    chk("second decide", boot_flow, FLOW_INITIAL_ROM);
    @(negedge clk);
    chk("unsec flow", boot_flow, FLOW_UNSECURE);
    freeze_chk();
    rd_chk("unsec status", `REG_BOOT_STATUS, 32'h0000_1010);
    rd_chk("locked id", `REG_SECURE_ID, 32'h0);
    rd_chk("read refused", `REG_BOOT_STATUS, 32'h0000_1018);
    wr(`REG_BOOT_CONTROL, 32'h4);
    rd_chk("refusal cleared", `REG_BOOT_STATUS, 32'h0000_1010);
    wr(`REG_SECURE_ID, 32'h0000_0707);
    rd_chk("refused", `REG_BOOT_STATUS, 32'h0000_1018);
    chk("ids kept", {cpu_master_id, dma_master_id}, 8'h5A);
    wr(`REG_BOOT_CONTROL, 32'h4);
    rd_chk("cleared", `REG_BOOT_STATUS, 32'h0000_1010);
    rd_chk("sense kept", `REG_MODE_SENSE, {26'h0, m, 1'b0, c});
    wr(`REG_BOOT_CONTROL, 32'h2);
    @(negedge clk);
    chk("final flow", boot_flow, serial ? FLOW_SERIAL_LOAD : FLOW_APPLICATION);
    chk("role", {mcu_role, secure_open}, serial ? 2'b00 : 2'b10);
    repeat (20) @(negedge clk);
    rd_chk("final status", `REG_BOOT_STATUS, serial ? 32'h0000_4010 : 32'h0000_2014);
    rd_chk("final locked", `REG_SECURE_ID, 32'h0);
  endtask

  initial begin
    boot_case(`STRAP_FOUR_WIRE, 2'h0, 3'b100);
    boot_case(`STRAP_TWO_WIRE, 2'h1, 3'b010);
    boot_case(`STRAP_SERIAL_LOAD, 2'h2, 3'b101);
    boot_case(3'h3, 2'h3, 3'b000);
    end_of_test();
  end

  // Four boots take well under this span
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
